/* File: src/timer_bypass.sv */
// timer register block: bus slave, bypass-mode gate and output ports, interrupt request
`timescale 1ns/1ps
module timer_bypass (
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        reset_in,
  input  wire logic        soft_reset_in,
  input  wire logic        freeze_in,
  // register access
  input  wire logic        bus_sel_in,
  input  wire logic        bus_write_in,
  input  wire logic        bus_super_in,
  input  wire logic [1:0]  bus_byte_en_in,
  input  wire logic [11:0] bus_addr_in,
  input  wire logic [15:0] bus_wdata_in,
  output logic             bus_ack_out,
  output logic             bus_err_out,
  output logic      [15:0] bus_rdata_out,
  // interrupt request and acknowledge
  output logic      [6:0]  request_line_out,
  input  wire logic        iack_cycle_in,
  input  wire logic [2:0]  iack_level_in,
  output logic             arb_bid_out,
  output logic      [3:0]  arb_id_out,
  input  wire logic        arb_win_in,
  output logic             vector_valid_out,
  output logic      [7:0]  vector_out,
  // pins
  input  wire logic        gate_input_pin_n_in,
  input  wire logic        timer_output_pin_in,
  output logic             timer_output_pin_out,
  output logic             timer_output_pin_oe_n_out
);

  typedef struct packed {
    logic [15:0] module_setup;
    logic [15:0] interrupt_setup;
    logic [15:0] timer_control;
    logic [15:0] first_reload;
    logic [15:0] second_reload;
    logic [15:0] match_value;
    logic        gate_event_flag;
    logic        gate_prev;
    logic        running;
    logic        out_level;
    logic        out_drive;
    logic        ack;
    logic        err;
    logic [15:0] rdata;
    logic        bid;
    logic        vec_valid;
    logic [7:0]  vector;
    logic [6:0]  request_line;
  } state_t;

  // gate history resets negated so leaving reset never looks like a negation
  localparam state_t STATE_RST = '{
    module_setup:    timer_pkg::SETUP_RESET,
    interrupt_setup: timer_pkg::IRQ_RESET,
    timer_control:   timer_pkg::CTRL_RESET,
    first_reload:    timer_pkg::DATA_RESET,
    second_reload:   timer_pkg::DATA_RESET,
    match_value:     timer_pkg::DATA_RESET,
    gate_event_flag: 1'b0,
    gate_prev:       1'b1,
    running:         1'b0,
    out_level:       1'b0,
    out_drive:       1'b0,
    ack:             1'b0,
    err:             1'b0,
    rdata:           timer_pkg::DATA_RESET,
    bid:             1'b0,
    vec_valid:       1'b0,
    vector:          8'h00,
    request_line:    7'h00
  };

  state_t st_r;
  state_t st_nxt;

  logic [1:0] pin_lvl;
  logic       gate_lvl;
  logic       out_pin_lvl;

  // both pins arrive from outside the clock domain
  pin_sync u_pin_sync (
    .clk_in    (clk_in),
    .reset_in  (reset_in),
    .raw_in    ({timer_output_pin_in, gate_input_pin_n_in}),
    .level_out (pin_lvl)
  );

  assign gate_lvl    = pin_lvl[0];  // high means negated
  assign out_pin_lvl = pin_lvl[1];

  // byte-lane merge that only touches writable bits
  function automatic logic [15:0] merge(input logic [15:0] old,
                                        input logic [15:0] wd,
                                        input logic [1:0]  be,
                                        input logic [15:0] wmask);
    logic [15:0] lane;
    lane = {{8{be[1]}}, {8{be[0]}}} & wmask;
    merge = (old & ~lane) | (wd & lane);
  endfunction : merge

  // decode of the current state and of the access on the bus
  logic        halted;
  logic        frozen;
  logic        run;
  logic        bypass;
  logic [2:0]  src_en;
  logic [2:0]  flags;
  logic        pending;
  logic [2:0]  req_level;
  logic        hit;
  logic        sup_only;
  logic        priv_fault;
  logic        halt_fault;
  logic        good;
  logic        do_write;
  logic        tg_set;
  logic        tg_clear;
  logic [15:0] state_word;
  logic [15:0] rd;
  logic [1:0]  oc_code;
  logic        arb_enter;
  logic [6:0]  lvl_match;

  // one comparator per request level; level zero raises no line
  for (genvar lv = 0; lv < 7; lv++) begin : g_level
    assign lvl_match[lv] = st_r.interrupt_setup[timer_pkg::IRQ_LVL_HI:timer_pkg::IRQ_LVL_LO]
                           == 3'(lv + 1);
  end

  always_comb begin
    halted    = st_r.module_setup[timer_pkg::SETUP_HALT];
    // debug halt codes 00 and 01 ignore the freeze request
    unique case (st_r.module_setup[timer_pkg::SETUP_FRZ_HI:timer_pkg::SETUP_FRZ_LO])
      2'h0, 2'h1: frozen = 1'b0;
      2'h2, 2'h3: frozen = freeze_in;
    endcase
    run       = ~halted & ~frozen;
    bypass    = st_r.timer_control[timer_pkg::CTRL_MODE_HI:timer_pkg::CTRL_MODE_LO]
                == timer_pkg::MODE_BYPASS;
    src_en    = st_r.timer_control[timer_pkg::CTRL_IE_HI:timer_pkg::CTRL_IE_LO];
    // timeout and compare-hit never set while the counter stays disabled
    flags     = 3'h0;
    flags[timer_pkg::IE_GATE] = st_r.gate_event_flag;
    pending   = |(src_en & flags);
    req_level = st_r.interrupt_setup[timer_pkg::IRQ_LVL_HI:timer_pkg::IRQ_LVL_LO];
    oc_code   = st_r.timer_control[timer_pkg::CTRL_OC_HI:0];

    // bus decode
    hit      = bus_sel_in && (bus_addr_in >= timer_pkg::OFF_SETUP)
               && (bus_addr_in <= timer_pkg::OFF_LAST);
    sup_only = bus_addr_in < timer_pkg::OFF_CONTROL;
    // user accesses fail on supervisor-only offsets and, with the privilege bit set, on all
    priv_fault = !bus_super_in
                 && (sup_only || st_r.module_setup[timer_pkg::SETUP_PRIV]);
    halt_fault = halted && bus_addr_in != timer_pkg::OFF_SETUP;
    good       = hit && !priv_fault && !halt_fault;
    do_write = good && bus_write_in;

    // timer_state word; bypass shows idle prescaler and cleared counter flags
    state_word = {pending,
                  1'b0,
                  st_r.gate_event_flag,
                  1'b0,
                  gate_lvl,
                  st_r.running,
                  out_pin_lvl,
                  1'b0,
                  timer_pkg::PRESCALER_IDLE};

    rd = timer_pkg::DATA_RESET;
    unique case (bus_addr_in)
      timer_pkg::OFF_SETUP:     rd = st_r.module_setup;
      timer_pkg::OFF_IRQ_SETUP: rd = st_r.interrupt_setup;
      timer_pkg::OFF_CONTROL:   rd = st_r.timer_control;
      timer_pkg::OFF_STATE:     rd = state_word;
      timer_pkg::OFF_RELOAD1:   rd = st_r.first_reload;
      timer_pkg::OFF_RELOAD2:   rd = st_r.second_reload;
      timer_pkg::OFF_MATCH:     rd = st_r.match_value;
      default:                  rd = timer_pkg::DATA_RESET;
    endcase

    // bus answer: a registered pulse one cycle after the access
    st_nxt           = st_r;
    st_nxt.ack       = hit && good;
    st_nxt.err       = hit && !good;
    // read data stands only in the answer cycle of a read
    if (good && !bus_write_in) begin
      st_nxt.rdata = rd;
    end else begin
      st_nxt.rdata = timer_pkg::DATA_RESET;
    end
    st_nxt.bid       = 1'b0;
    st_nxt.vec_valid = 1'b0;

    // gate and output port behaviour, held while halted or frozen
    tg_set = 1'b0;
    if (run) begin
      st_nxt.gate_prev = gate_lvl;
      // only the port view of the gate runs; no counter or prescaler is ever clocked
      if (bypass && st_r.timer_control[timer_pkg::CTRL_CPE]) begin
        st_nxt.running = !gate_lvl;
      end else begin
        st_nxt.running = 1'b0;
      end
      tg_set = bypass && gate_lvl && !st_r.gate_prev;
      if (!st_r.timer_control[timer_pkg::CTRL_SWR]) begin
        unique case (oc_code)
          timer_pkg::OC_HIZ: begin
            st_nxt.out_drive = 1'b0;
            st_nxt.out_level = 1'b0;
          end
          timer_pkg::OC_ONE: begin
            st_nxt.out_drive = 1'b1;
            st_nxt.out_level = 1'b1;
          end
          default: begin
            st_nxt.out_drive = 1'b1;
            st_nxt.out_level = 1'b0;
          end
        endcase
      end
    end

    // register writes; read-only and reserved bits drop the data
    tg_clear = 1'b0;
    if (do_write) begin
      unique case (bus_addr_in)
        timer_pkg::OFF_SETUP: begin
          st_nxt.module_setup = merge(st_r.module_setup, bus_wdata_in, bus_byte_en_in,
                                      timer_pkg::SETUP_WMASK);
        end
        timer_pkg::OFF_IRQ_SETUP: begin
          st_nxt.interrupt_setup = merge(st_r.interrupt_setup, bus_wdata_in,
                                         bus_byte_en_in, timer_pkg::IRQ_WMASK);
        end
        timer_pkg::OFF_CONTROL: begin
          st_nxt.timer_control = merge(st_r.timer_control, bus_wdata_in, bus_byte_en_in,
                                       16'hffff);
        end
        timer_pkg::OFF_STATE: begin
          tg_clear = bus_byte_en_in[1] && bus_wdata_in[timer_pkg::STATE_TG];
        end
        timer_pkg::OFF_RELOAD1: begin
          st_nxt.first_reload = merge(st_r.first_reload, bus_wdata_in, bus_byte_en_in,
                                      16'hffff);
        end
        timer_pkg::OFF_RELOAD2: begin
          st_nxt.second_reload = merge(st_r.second_reload, bus_wdata_in,
                                       bus_byte_en_in, 16'hffff);
        end
        timer_pkg::OFF_MATCH: begin
          st_nxt.match_value = merge(st_r.match_value, bus_wdata_in, bus_byte_en_in,
                                     16'hffff);
        end
        default: begin
        end
      endcase
    end

    // a negation in the clearing cycle still leaves the flag set
    if (tg_set) begin
      st_nxt.gate_event_flag = 1'b1;
    end else if (tg_clear) begin
      st_nxt.gate_event_flag = 1'b0;
    end

    // request line follows the pending level one cycle later, through the state register
    st_nxt.request_line = pending ? lvl_match : 7'h00;

    // acknowledge: bid one cycle after the cycle, vector one cycle after a win
    arb_enter = iack_cycle_in && pending && req_level == iack_level_in;
    // an identifier of zero keeps the module out of arbitration
    if (arb_enter && st_r.module_setup[timer_pkg::SETUP_ARB_HI:0] != 4'h0) begin
      st_nxt.bid = 1'b1;
    end
    if (st_r.bid && arb_win_in) begin
      st_nxt.vec_valid = 1'b1;
      st_nxt.vector    = st_r.interrupt_setup[timer_pkg::IRQ_VEC_HI:0];
    end

    // reset instruction keeps module_setup and the ack/err answer; read data returns zero
    // a write landing in this cycle is lost, but the access is still answered
    if (soft_reset_in) begin
      st_nxt              = STATE_RST;
      st_nxt.module_setup = st_r.module_setup;
      st_nxt.ack          = hit && good;
      st_nxt.err          = hit && !good;
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      st_r <= STATE_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // every output comes straight from the state register
  assign bus_ack_out               = st_r.ack;
  assign bus_err_out               = st_r.err;
  assign bus_rdata_out             = st_r.rdata;
  assign request_line_out          = st_r.request_line;
  assign arb_bid_out               = st_r.bid;
  assign arb_id_out                = st_r.bid ? st_r.module_setup[timer_pkg::SETUP_ARB_HI:0]
                                              : 4'h0;
  assign vector_valid_out          = st_r.vec_valid;
  assign vector_out                = st_r.vector;
  assign timer_output_pin_out      = st_r.out_level;
  assign timer_output_pin_oe_n_out = ~st_r.out_drive;

endmodule : timer_bypass

/* File: common/timer_pkg.sv */
// constants for the general-purpose timer register block and its bypass port logic
package timer_pkg;

  // register offsets on the internal module bus
  localparam logic [11:0] OFF_SETUP     = 12'h600;
  localparam logic [11:0] OFF_GAP       = 12'h602;
  localparam logic [11:0] OFF_IRQ_SETUP = 12'h604;
  localparam logic [11:0] OFF_CONTROL   = 12'h606;
  localparam logic [11:0] OFF_STATE     = 12'h608;
  localparam logic [11:0] OFF_COUNT     = 12'h60a;
  localparam logic [11:0] OFF_RELOAD1   = 12'h60c;
  localparam logic [11:0] OFF_RELOAD2   = 12'h60e;
  localparam logic [11:0] OFF_MATCH     = 12'h610;
  localparam logic [11:0] OFF_LAST      = 12'h63f;

  // module_setup fields
  localparam int SETUP_HALT   = 15;
  localparam int SETUP_FRZ_HI = 14;
  localparam int SETUP_FRZ_LO = 13;
  localparam int SETUP_PRIV   = 7;
  localparam int SETUP_ARB_HI = 3;
  localparam logic [15:0] SETUP_WMASK = 16'he08f;
  localparam logic [15:0] SETUP_RESET = 16'h0080;

  // interrupt_setup fields
  localparam int IRQ_LVL_HI = 10;
  localparam int IRQ_LVL_LO = 8;
  localparam int IRQ_VEC_HI = 7;
  localparam logic [15:0] IRQ_WMASK = 16'h07ff;
  localparam logic [15:0] IRQ_RESET = 16'h000f;

  // timer_control fields
  localparam int CTRL_SWR    = 15;
  localparam int CTRL_IE_HI  = 14;
  localparam int CTRL_IE_LO  = 12;
  localparam int CTRL_CPE    = 9;
  localparam int CTRL_MODE_HI = 4;
  localparam int CTRL_MODE_LO = 2;
  localparam int CTRL_OC_HI  = 1;
  localparam logic [15:0] CTRL_RESET = 16'h0000;

  // timer_state fields
  localparam int STATE_TG = 13;
  localparam logic [7:0] PRESCALER_IDLE = 8'hff;

  // source enable weights: timeout, gate, compare-hit
  localparam int IE_TIMEOUT = 2;
  localparam int IE_GATE    = 1;
  localparam int IE_COMPARE = 0;

  localparam logic [2:0] MODE_BYPASS = 3'h7;

  // output control codes
  localparam logic [1:0] OC_HIZ  = 2'h0;
  localparam logic [1:0] OC_ONE  = 2'h3;

  localparam logic [15:0] DATA_RESET = 16'h0000;

endpackage : timer_pkg

/* File: src/pin_sync.sv */
// three-flop synchroniser for pin inputs; a level counts once stages two and three agree
`timescale 1ns/1ps
module pin_sync (
  // clock and reset
  input  wire logic       clk_in,
  input  wire logic       reset_in,
  // raw pins and filtered levels
  input  wire logic [1:0] raw_in,
  output logic      [1:0] level_out
);

  typedef struct packed {
    logic [1:0] s1;
    logic [1:0] s2;
    logic [1:0] s3;
    logic [1:0] lvl;
  } sync_t;

  sync_t st_r;
  sync_t st_nxt;

  always_comb begin
    st_nxt    = st_r;
    st_nxt.s1 = raw_in;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    for (int i = 0; i < 2; i++) begin
      if (st_r.s2[i] == st_r.s3[i]) begin
        st_nxt.lvl[i] = st_r.s3[i];
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      st_r <= '{s1: 2'h3, s2: 2'h3, s3: 2'h3, lvl: 2'h3};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign level_out = st_r.lvl;

endmodule : pin_sync

/* File: verif/timer_bypass_checker.sv */
// port-level assertions for the timer register block
`timescale 1ns/1ps
module timer_bypass_checker (
  // clock and reset
  input wire logic        clk_in,
  input wire logic        reset_in,
  // register access
  input wire logic        bus_sel_in,
  input wire logic        bus_write_in,
  input wire logic        bus_super_in,
  input wire logic [11:0] bus_addr_in,
  input wire logic        bus_ack_out,
  input wire logic        bus_err_out,
  input wire logic [15:0] bus_rdata_out,
  // interrupt side
  input wire logic [6:0]  request_line_out,
  input wire logic        iack_cycle_in,
  input wire logic        arb_bid_out,
  input wire logic [3:0]  arb_id_out,
  input wire logic        arb_win_in,
  input wire logic        vector_valid_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);
  logic in_range;
  assign in_range = bus_addr_in >= timer_pkg::OFF_SETUP && bus_addr_in <= timer_pkg::OFF_LAST;

  ack_one_cycle_a: assert property (bus_sel_in && in_range |=> bus_ack_out ^ bus_err_out)
    else $error("access not answered in one cycle");
  no_stray_ack_a: assert property (!bus_sel_in |=> !bus_ack_out && !bus_err_out)
    else $error("answer without access");
  rdata_idle_a: assert property (!bus_ack_out |-> bus_rdata_out == 16'h0000)
    else $error("read data outside ack cycle");
  super_only_a: assert property (bus_sel_in && !bus_super_in && bus_addr_in <= 12'h605
    && bus_addr_in >= timer_pkg::OFF_SETUP |=> bus_err_out)
    else $error("user access to supervisor register accepted");
  reserved_zero_a: assert property (bus_sel_in && !bus_write_in && (bus_addr_in == 12'h602
    || (bus_addr_in >= 12'h612 && bus_addr_in <= 12'h63f)) |=> bus_rdata_out == 16'h0000)
    else $error("reserved read not zero");
  state_bits_a: assert property (bus_sel_in && !bus_write_in && bus_addr_in == 12'h608
    ##1 bus_ack_out |-> bus_rdata_out[7:0] == 8'hff && {bus_rdata_out[14],
    bus_rdata_out[12], bus_rdata_out[8]} == 3'h0)
    else $error("state read shows counting flags");
  vector_win_a: assert property (arb_bid_out && arb_win_in |=> vector_valid_out)
    else $error("won arbitration without vector");
  vector_cause_a: assert property (vector_valid_out |-> $past(arb_bid_out && arb_win_in))
    else $error("vector without won bid");
  bid_cause_a: assert property (arb_bid_out |-> $past(iack_cycle_in) && arb_id_out != 4'h0)
    else $error("bid without acknowledge or with zero id");
  one_line_a: assert property ($onehot0(request_line_out))
    else $error("more than one request line");
endmodule : timer_bypass_checker

bind timer_bypass timer_bypass_checker u_chk (.clk_in(clk_in), .reset_in(reset_in),
  .bus_sel_in(bus_sel_in), .bus_write_in(bus_write_in), .bus_super_in(bus_super_in),
  .bus_addr_in(bus_addr_in), .bus_ack_out(bus_ack_out), .bus_err_out(bus_err_out),
  .bus_rdata_out(bus_rdata_out), .request_line_out(request_line_out),
  .iack_cycle_in(iack_cycle_in), .arb_bid_out(arb_bid_out), .arb_id_out(arb_id_out),
  .arb_win_in(arb_win_in), .vector_valid_out(vector_valid_out));

/* File: verif/cpu_model.sv */
// processor-side model: register accesses and acknowledge cycles
`timescale 1ns/1ps
module cpu_model (
  input  wire logic        clk_in,
  input  wire logic        ack_in,
  input  wire logic        err_in,
  input  wire logic [15:0] rdata_in,
  input  wire logic        bid_in,
  input  wire logic [3:0]  id_in,
  input  wire logic        vv_in,
  input  wire logic [7:0]  vec_in,
  output logic             sel_out,
  output logic             write_out,
  output logic             super_out,
  output logic [1:0]       byte_en_out,
  output logic [11:0]      addr_out,
  output logic [15:0]      wdata_out,
  output logic             iack_out,
  output logic [2:0]       iack_level_out,
  output logic             win_out
);
  logic grant;
  initial begin
    {sel_out, write_out, super_out, iack_out, grant} = '0;
    byte_en_out = 2'h3;
    addr_out = 12'h600;
    wdata_out = 16'h0000;
    iack_level_out = 3'h0;
  end
  // arbiter grants in the bid cycle only when enabled
  assign win_out = bid_in & grant;

  task automatic access(input logic w, input logic s, input logic [1:0] be,
                        input logic [11:0] a, input logic [15:0] d,
                        output logic ack, output logic err, output logic [15:0] rd);
    {sel_out, write_out, super_out, byte_en_out, addr_out, wdata_out} = {1'b1, w, s, be, a, d};
    @(posedge clk_in);
    #2;
    sel_out = 1'b0;
    ack = ack_in;
    err = err_in;
    rd = rdata_in;
    @(posedge clk_in);
    #2;
  endtask : access

  task automatic iack(input logic [2:0] lvl, input logic g, output logic bid,
                      output logic [3:0] id, output logic vv, output logic [7:0] vec);
    iack_out = 1'b1;
    iack_level_out = lvl;
    grant = g;
    @(posedge clk_in);
    #2;
    iack_out = 1'b0;
    bid = bid_in;
    id = id_in;
    @(posedge clk_in);
    #2;
    vv = vv_in;
    vec = vec_in;
    grant = 1'b0;
    @(posedge clk_in);
    #2;
  endtask : iack
endmodule : cpu_model

/* File: verif/timer_bypass_tb.sv */
// self-checking bench for the timer register block in bypass mode
`timescale 1ns/1ps
module timer_bypass_tb;
  logic clk_in = 0, reset_in = 1, soft_reset_in = 0, gate_n = 1, freeze = 0;
  logic sel, wr, sup, ack, err, bid, win, iack, oe_n, pin_out, valid;
  logic [1:0] be;
  logic [11:0] addr;
  logic [15:0] wd, rdata;
  logic [6:0] req;
  logic [2:0] ilvl;
  logic [3:0] id;
  logic [7:0] vec;
  int n_fail = 0, n_checks = 0, cyc = 0;
  wire pin_level = oe_n ? 1'b1 : pin_out; // board pull-up when not driven

  initial forever #12.5 clk_in = ~clk_in;
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      print_verdict();
    end
  end

  cpu_model u_cpu (.clk_in(clk_in), .ack_in(ack), .err_in(err), .rdata_in(rdata),
    .bid_in(bid), .id_in(id), .vv_in(valid), .vec_in(vec), .sel_out(sel), .write_out(wr),
    .super_out(sup), .byte_en_out(be),
    .addr_out(addr), .wdata_out(wd), .iack_out(iack), .iack_level_out(ilvl), .win_out(win));
  timer_bypass u_dut (.clk_in(clk_in), .reset_in(reset_in), .soft_reset_in(soft_reset_in),
    .freeze_in(freeze), .bus_sel_in(sel), .bus_write_in(wr), .bus_super_in(sup),
    .bus_byte_en_in(be), .bus_addr_in(addr), .bus_wdata_in(wd), .bus_ack_out(ack),
    .bus_err_out(err), .bus_rdata_out(rdata), .request_line_out(req), .iack_cycle_in(iack),
    .iack_level_in(ilvl), .arb_bid_out(bid), .arb_id_out(id), .arb_win_in(win),
    .vector_valid_out(valid), .vector_out(vec), .gate_input_pin_n_in(gate_n),
    .timer_output_pin_in(pin_level), .timer_output_pin_out(pin_out),
    .timer_output_pin_oe_n_out(oe_n));

  task automatic chk16(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk16

  task automatic chk1(input string what, input logic exp, input logic got);
    chk16(what, {15'h0, exp}, {15'h0, got});
  endtask : chk1

  // access with expected answer; reads compare data, err expects bus error
  task automatic acc(input logic w, input logic s, input logic [1:0] b, input logic [11:0] a,
                     input logic [15:0] d, input logic e);
    logic k, x;
    logic [15:0] r;
    u_cpu.access(w, s, b, a, d, k, x, r);
    chk1("bus error", e, x);
    chk1("bus ack", !e, k);
    if (!w && !e) chk16($sformatf("read %h", a), d, r);
  endtask : acc

  task automatic t_reset_and_privilege();
    acc(0, 1, 2'h3, 12'h600, 16'h0080, 0);
    acc(0, 1, 2'h3, 12'h604, 16'h000f, 0);
    acc(0, 1, 2'h3, 12'h608, 16'h0aff, 0);
    acc(0, 0, 2'h3, 12'h606, 16'h0000, 1);
    acc(0, 0, 2'h3, 12'h600, 16'h0000, 1);
    acc(1, 1, 2'h3, 12'h600, 16'h0003, 0);
    acc(0, 0, 2'h3, 12'h606, 16'h0000, 0);
    acc(1, 1, 2'h3, 12'h602, 16'hffff, 0);
    acc(0, 1, 2'h3, 12'h602, 16'h0000, 0);
    acc(0, 0, 2'h3, 12'h63e, 16'h0000, 0);
    acc(1, 1, 2'h3, 12'h60a, 16'h5555, 0);
    acc(0, 1, 2'h3, 12'h60a, 16'h0000, 0);
  endtask : t_reset_and_privilege

  task automatic t_output_port();
    for (int oc = 0; oc < 4; oc++) begin
      acc(1, 1, 2'h3, 12'h606, 16'h001c | oc[15:0], 0);
      repeat (6) @(posedge clk_in);
      #2;
      chk1("pin enable", oc == 0, oe_n);
      if (oc != 0) chk1("pin level", oc == 3, pin_out);
      acc(0, 1, 2'h3, 12'h608, {4'h0, 1'b1, 1'b0, oc != 2 && oc != 1, 1'b0, 8'hff}, 0);
    end
    acc(1, 1, 2'h3, 12'h606, 16'h801e, 0);
    repeat (4) @(posedge clk_in);
    #2;
    chk1("pin held", 1'b1, pin_out);
  endtask : t_output_port

  task automatic t_gate_interrupt();
    logic b, v;
    logic [3:0] i;
    logic [7:0] n;
    acc(1, 1, 2'h3, 12'h604, 16'h0542, 0);
    acc(1, 1, 2'h3, 12'h606, 16'h221c, 0);
    gate_n = 0;
    repeat (8) @(posedge clk_in);
    #2;
    acc(0, 1, 2'h3, 12'h608, 16'h06ff, 0);
    gate_n = 1;
    repeat (8) @(posedge clk_in);
    #2;
    acc(0, 1, 2'h3, 12'h608, 16'haaff, 0);
    chk16("request", 16'h0010, {9'h0, req});
    acc(1, 1, 2'h3, 12'h608, 16'h0000, 0);
    acc(0, 1, 2'h3, 12'h608, 16'haaff, 0);
    u_cpu.iack(3'h4, 1'b1, b, i, v, n);
    chk1("bid wrong level", 1'b0, b);
    u_cpu.iack(3'h5, 1'b1, b, i, v, n);
    chk1("bid", 1'b1, b);
    chk16("bid id", 16'h0003, {12'h0, i});
    chk1("vector valid", 1'b1, v);
    chk16("vector", 16'h0042, {8'h0, n});
    acc(1, 1, 2'h2, 12'h608, 16'h2000, 0);
    acc(0, 1, 2'h3, 12'h608, 16'h0aff, 0);
    chk16("request cleared", 16'h0000, {9'h0, req});
  endtask : t_gate_interrupt

  task automatic t_halt_and_soft_reset();
    acc(1, 1, 2'h3, 12'h600, 16'h8003, 0);
    acc(0, 1, 2'h3, 12'h606, 16'h0000, 1);
    acc(0, 1, 2'h3, 12'h604, 16'h0000, 1);
    acc(0, 1, 2'h3, 12'h600, 16'h8003, 0);
    acc(1, 1, 2'h3, 12'h600, 16'h0003, 0);
    acc(1, 1, 2'h3, 12'h60c, 16'h1234, 0);
    soft_reset_in = 1;
    @(posedge clk_in);
    #2;
    soft_reset_in = 0;
    acc(0, 1, 2'h3, 12'h60c, 16'h0000, 0);
    acc(0, 1, 2'h3, 12'h600, 16'h0003, 0);
    acc(0, 1, 2'h3, 12'h604, 16'h000f, 0);
    acc(1, 1, 2'h1, 12'h60c, 16'habcd, 0);
    acc(0, 1, 2'h3, 12'h60c, 16'h00cd, 0);
  endtask : t_halt_and_soft_reset

  // freeze holds the gate port; a zero identifier keeps the module from bidding
  task automatic t_freeze_and_arb();
    logic b, v;
    logic [3:0] i;
    logic [7:0] n;
    acc(1, 1, 2'h3, 12'h604, 16'h0542, 0);
    acc(1, 1, 2'h3, 12'h606, 16'h221c, 0);
    acc(1, 1, 2'h3, 12'h600, 16'h4003, 0);
    freeze = 1;
    gate_n = 0;
    repeat (8) @(posedge clk_in);
    #2;
    acc(0, 1, 2'h3, 12'h608, 16'h02ff, 0);
    freeze = 0;
    repeat (4) @(posedge clk_in);
    #2;
    acc(0, 1, 2'h3, 12'h608, 16'h06ff, 0);
    acc(1, 1, 2'h3, 12'h600, 16'h0000, 0);
    gate_n = 1;
    repeat (8) @(posedge clk_in);
    #2;
    acc(0, 1, 2'h3, 12'h608, 16'haaff, 0);
    chk16("request again", 16'h0010, {9'h0, req});
    u_cpu.iack(3'h5, 1'b1, b, i, v, n);
    chk1("bid with zero id", 1'b0, b);
    chk1("vector without bid", 1'b0, v);
    acc(1, 1, 2'h2, 12'h608, 16'h2000, 0);
    chk16("request dropped", 16'h0000, {9'h0, req});
  endtask : t_freeze_and_arb

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : print_verdict

  initial begin
    repeat (12) @(posedge clk_in);
    #2;
    reset_in = 0;
    t_reset_and_privilege();
    t_output_port();
    t_gate_interrupt();
    t_halt_and_soft_reset();
    t_freeze_and_arb();
    print_verdict();
  end
endmodule : timer_bypass_tb
